// ### ocp_defines.svh
// Register indices, field positions and reset values of the compare channel pair
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH

// Register indices; byte address on the bus is four times the index
`define OCP_IDX_CH1_SEC   10'h180
`define OCP_IDX_CH1_PRI   10'h182
`define OCP_IDX_CH1_CTRL  10'h184
`define OCP_IDX_CH2_SEC   10'h186
`define OCP_IDX_CH2_PRI   10'h188
`define OCP_IDX_CH2_CTRL  10'h18A

// Control register fields
`define OCP_CTRL_MODE_LSB   0
`define OCP_CTRL_MODE_MSB   2
`define OCP_CTRL_TSEL_BIT   3
`define OCP_CTRL_FLT_BIT    4
`define OCP_CTRL_SIDL_BIT   13
`define OCP_CTRL_FRZ_BIT    14

// Reset values
`define OCP_RST_SEC   16'h0000
`define OCP_RST_PRI   16'h0000
`define OCP_RST_MODE  3'h0

`endif

// ### ocp_pkg.sv
// Types shared by the compare channel pair
`default_nettype none

package ocp_pkg;

   typedef enum logic [2:0] {
      OCP_OFF     = 3'h0,
      OCP_LOW     = 3'h1,
      OCP_HIGH    = 3'h2,
      OCP_TOGGLE  = 3'h3,
      OCP_SINGLE  = 3'h4,
      OCP_CONT    = 3'h5,
      OCP_PWM     = 3'h6,
      OCP_PWM_FLT = 3'h7
   } ocp_mode_t;

   typedef enum logic [1:0] {
      OCP_K_SEC  = 2'h0,
      OCP_K_PRI  = 2'h1,
      OCP_K_CTRL = 2'h2
   } ocp_kind_t;

   // One external timebase as seen by the channels
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic        run;
      logic        idle_stop;
      logic        tick;
   } ocp_tb_t;

   typedef struct packed {
      logic      hit;
      logic      ch;
      ocp_kind_t kind;
   } ocp_dec_t;

endpackage

`default_nettype wire

// ### ocp_channel_pair.sv
// Two output compare / PWM channels with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defines.svh"

module ocp_channel_pair
   import ocp_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        SYS_RST,
   input  wire logic [11:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire ocp_tb_t     TB1,
   input  wire ocp_tb_t     TB2,
   input  wire logic        CPU_SLEEP,
   input  wire logic        CPU_IDLE,
   input  wire logic        DEBUG_HALT,
   input  wire logic [1:0]  FAULT_IN_N,
   output logic      [1:0]  CMP_OUT,
   output logic      [1:0]  CMP_OE,
   output logic      [1:0]  CMP_EVENT,
   output logic      [1:0]  TB_EVENT
);

   function automatic ocp_dec_t decode(input logic [9:0] idx);
      ocp_dec_t d;
      d = '0;
      case (idx)
         `OCP_IDX_CH1_SEC: begin
            d = '{hit: 1'b1, ch: 1'b0, kind: OCP_K_SEC};
         end
         `OCP_IDX_CH1_PRI: begin
            d = '{hit: 1'b1, ch: 1'b0, kind: OCP_K_PRI};
         end
         `OCP_IDX_CH1_CTRL: begin
            d = '{hit: 1'b1, ch: 1'b0, kind: OCP_K_CTRL};
         end
         `OCP_IDX_CH2_SEC: begin
            d = '{hit: 1'b1, ch: 1'b1, kind: OCP_K_SEC};
         end
         `OCP_IDX_CH2_PRI: begin
            d = '{hit: 1'b1, ch: 1'b1, kind: OCP_K_PRI};
         end
         `OCP_IDX_CH2_CTRL: begin
            d = '{hit: 1'b1, ch: 1'b1, kind: OCP_K_CTRL};
         end
         default: begin
            d = '0;
         end
      endcase
      return d;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic is_pwm(input ocp_mode_t m);
      return (m == OCP_PWM) || (m == OCP_PWM_FLT);
   endfunction

   logic      [15:0] sec_reg   [2];
   logic      [15:0] pri_reg   [2];
   ocp_mode_t        mode_reg  [2];
   logic      [1:0]  tsel_reg;
   logic      [1:0]  sidl_reg;
   logic      [1:0]  frz_reg;
   logic      [1:0]  fault_reg;
   logic      [1:0]  armed_reg;

   ocp_dec_t         dec;
   logic             wr_go;
   logic             rd_first;
   logic      [15:0] rd_word;

   ocp_tb_t          tb        [2];
   logic      [1:0]  act;
   logic      [1:0]  m_pri;
   logic      [1:0]  m_sec;
   logic      [1:0]  wrap;
   logic      [1:0]  ctrl_wr;
   logic      [1:0]  cmp_ev_next;
   logic      [1:0]  tb_ev_next;

   assign dec      = decode(AVS_ADDRESS[11:2]);
   assign wr_go    = AVS_WRITE && !AVS_WAITREQUEST;
   assign rd_first = AVS_READ && AVS_WAITREQUEST;

   // Bus handshake: one wait cycle, then completion
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         AVS_WAITREQUEST <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
         AVS_WAITREQUEST <= 1'b0;
      end else begin
         AVS_WAITREQUEST <= 1'b1;
      end
   end

   always_comb begin
      rd_word = 16'h0000;
      if (dec.hit) begin
         case (dec.kind)
            OCP_K_SEC: begin
               rd_word = sec_reg[dec.ch];
            end
            OCP_K_PRI: begin
               rd_word = pri_reg[dec.ch];
            end
            OCP_K_CTRL: begin
               rd_word[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB] = mode_reg[dec.ch];
               rd_word[`OCP_CTRL_TSEL_BIT] = tsel_reg[dec.ch];
               rd_word[`OCP_CTRL_FLT_BIT]  = fault_reg[dec.ch];
               rd_word[`OCP_CTRL_SIDL_BIT] = sidl_reg[dec.ch];
               rd_word[`OCP_CTRL_FRZ_BIT]  = frz_reg[dec.ch];
            end
            default: begin
               rd_word = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (rd_first) begin
         AVS_READDATA <= {16'h0000, rd_word};
      end
   end

   // Per-channel view of the selected timebase and match decoding
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         tb[c]      = tsel_reg[c] ? TB2 : TB1;
         // Sleep and debug freeze stop the channel; idle only when allowed
         act[c]     = (mode_reg[c] != OCP_OFF) && !CPU_SLEEP
                      && !(DEBUG_HALT && frz_reg[c])
                      && !(CPU_IDLE && (sidl_reg[c] || !tb[c].run
                                        || tb[c].idle_stop));
         m_pri[c]   = act[c] && tb[c].tick && (tb[c].count == pri_reg[c]);
         m_sec[c]   = act[c] && tb[c].tick && (tb[c].count == sec_reg[c]);
         // Count just cleared after reaching the period value
         wrap[c]    = act[c] && tb[c].tick && (tb[c].count == 16'h0000);
         ctrl_wr[c] = wr_go && dec.hit && (dec.kind == OCP_K_CTRL)
                      && (dec.ch == 1'(c)) && AVS_BYTEENABLE[0];
      end
   end

   // Compare and timebase event pulses
   always_comb begin
      cmp_ev_next = 2'b00;
      tb_ev_next  = 2'b00;
      for (int c = 0; c < 2; c++) begin
         case (mode_reg[c])
            OCP_LOW, OCP_HIGH, OCP_TOGGLE: begin
               cmp_ev_next[c] = m_pri[c];
            end
            OCP_SINGLE: begin
               cmp_ev_next[c] = armed_reg[c] && (m_pri[c] || m_sec[c]);
            end
            OCP_CONT: begin
               cmp_ev_next[c] = m_pri[c] || m_sec[c];
            end
            OCP_PWM, OCP_PWM_FLT: begin
               if (wrap[c]) begin
                  tb_ev_next[tsel_reg[c]] = 1'b1;
               end
            end
            default: begin
               cmp_ev_next[c] = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CMP_EVENT <= 2'b00;
         TB_EVENT  <= 2'b00;
      end else begin
         CMP_EVENT <= cmp_ev_next;
         TB_EVENT  <= tb_ev_next;
      end
   end

   // Software-visible configuration
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int c = 0; c < 2; c++) begin
            sec_reg[c]  <= `OCP_RST_SEC;
            mode_reg[c] <= ocp_mode_t'(`OCP_RST_MODE);
         end
         tsel_reg <= 2'b00;
         sidl_reg <= 2'b00;
         frz_reg  <= 2'b00;
      end else if (wr_go && dec.hit) begin
         case (dec.kind)
            OCP_K_SEC: begin
               sec_reg[dec.ch] <= merge16(sec_reg[dec.ch], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            OCP_K_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  mode_reg[dec.ch] <= ocp_mode_t'(
                     AVS_WRITEDATA[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB]);
                  tsel_reg[dec.ch] <= AVS_WRITEDATA[`OCP_CTRL_TSEL_BIT];
               end
               if (AVS_BYTEENABLE[1]) begin
                  sidl_reg[dec.ch] <= AVS_WRITEDATA[`OCP_CTRL_SIDL_BIT];
                  frz_reg[dec.ch]  <= AVS_WRITEDATA[`OCP_CTRL_FRZ_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Primary compare: software value, or active duty latch in PWM
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int c = 0; c < 2; c++) begin
            pri_reg[c] <= `OCP_RST_PRI;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (is_pwm(mode_reg[c])) begin
               if (wrap[c]) begin
                  pri_reg[c] <= sec_reg[c];
               end
            end else if (wr_go && dec.hit && dec.kind == OCP_K_PRI
                         && dec.ch == 1'(c)) begin
               pri_reg[c] <= merge16(pri_reg[c], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
         end
      end
   end

   // Single pulse arming; a write of mode 100 rearms
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         armed_reg <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (ctrl_wr[c] && AVS_WRITEDATA[`OCP_CTRL_MODE_MSB:`OCP_CTRL_MODE_LSB]
                == OCP_SINGLE) begin
               armed_reg[c] <= 1'b1;
            end else if (mode_reg[c] == OCP_SINGLE && m_sec[c]) begin
               armed_reg[c] <= 1'b0;
            end
         end
      end
   end

   // Fault latch; a new fault wins over the clearing write
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         fault_reg <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (mode_reg[c] == OCP_PWM_FLT && !FAULT_IN_N[c]) begin
               fault_reg[c] <= 1'b1;
            end else if (ctrl_wr[c] && FAULT_IN_N[c]
                         && AVS_WRITEDATA[`OCP_CTRL_MODE_MSB]
                         && AVS_WRITEDATA[`OCP_CTRL_MODE_MSB - 1]) begin
               fault_reg[c] <= 1'b0;
            end
         end
      end
   end

   // Output enable drops while a fault is latched
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CMP_OE <= 2'b11;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (mode_reg[c] == OCP_PWM_FLT && !FAULT_IN_N[c]) begin
               CMP_OE[c] <= 1'b0;
            end else if (fault_reg[c] && !(ctrl_wr[c] && FAULT_IN_N[c]
                         && AVS_WRITEDATA[`OCP_CTRL_MODE_MSB]
                         && AVS_WRITEDATA[`OCP_CTRL_MODE_MSB - 1])) begin
               CMP_OE[c] <= 1'b0;
            end else begin
               CMP_OE[c] <= 1'b1;
            end
         end
      end
   end

   // Pin level; an inactive channel simply holds its level
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CMP_OUT <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            case (mode_reg[c])
               OCP_LOW: begin
                  if (m_pri[c]) begin
                     CMP_OUT[c] <= 1'b0;
                  end
               end
               OCP_HIGH: begin
                  if (m_pri[c]) begin
                     CMP_OUT[c] <= 1'b1;
                  end
               end
               OCP_TOGGLE: begin
                  if (m_pri[c]) begin
                     CMP_OUT[c] <= !CMP_OUT[c];
                  end
               end
               OCP_SINGLE: begin
                  if (armed_reg[c] && m_sec[c]) begin
                     CMP_OUT[c] <= 1'b0;
                  end else if (armed_reg[c] && m_pri[c]) begin
                     CMP_OUT[c] <= 1'b1;
                  end
               end
               OCP_CONT: begin
                  if (m_sec[c]) begin
                     CMP_OUT[c] <= 1'b0;
                  end else if (m_pri[c]) begin
                     CMP_OUT[c] <= 1'b1;
                  end
               end
               OCP_PWM, OCP_PWM_FLT: begin
                  if (wrap[c]) begin
                     CMP_OUT[c] <= (sec_reg[c] != 16'h0000);
                  end else if (m_pri[c] && pri_reg[c] != 16'h0000) begin
                     // Duty beyond the period never matches, so the pin stays high
                     CMP_OUT[c] <= 1'b0;
                  end
               end
               default: begin
                  CMP_OUT[c] <= CMP_OUT[c];
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ### ocp_checker.sv
// Port-level assertions for the compare channel pair
`timescale 1ns/1ps
`default_nettype none

module ocp_checker
   import ocp_pkg::*;
(
   input wire logic       MCLK,
   input wire logic       SYS_RST,
   input wire logic       AVS_READ,
   input wire logic       AVS_WRITE,
   input wire logic       AVS_WAITREQUEST,
   input wire ocp_tb_t    TB1,
   input wire ocp_tb_t    TB2,
   input wire logic       CPU_SLEEP,
   input wire logic       CPU_IDLE,
   input wire logic [1:0] FAULT_IN_N,
   input wire logic [1:0] CMP_OUT,
   input wire logic [1:0] CMP_OE,
   input wire logic [1:0] CMP_EVENT,
   input wire logic [1:0] TB_EVENT
);
   default clocking dc @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   sequence s_req;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   // Frozen channels: pins held, no events
   sequence s_quiet;
      $stable(CMP_OUT) && CMP_EVENT == 2'h0 && TB_EVENT == 2'h0;
   endsequence

   a_bus_answer: assert property (s_req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not one cycle after request");
   a_sleep_hold: assert property (CPU_SLEEP |=> s_quiet)
      else $error("channel moved during sleep");
   a_idle_halt: assert property (CPU_IDLE && TB1.idle_stop && TB2.idle_stop |=> s_quiet)
      else $error("channel moved in idle with timebase stopped");
   a_fault_float: assert property ($fell(CMP_OE[1]) |-> !$past(FAULT_IN_N[1]))
      else $error("pin released without fault input");
   a_fault_hold: assert property (!CMP_OE[1] && !FAULT_IN_N[1] |=> !CMP_OE[1])
      else $error("pin driven while fault still present");
   a_fault_rearm: assert property ($rose(CMP_OE[1])
      |-> $past(AVS_WRITE && !AVS_WAITREQUEST && FAULT_IN_N[1]))
      else $error("pin driven again without control write");
   a_wrap_cause: assert property (TB_EVENT[0] |-> $past(TB1.tick && TB1.count == 16'h0000))
      else $error("period event without wrap");
   a_event_cause: assert property (CMP_EVENT[0] |-> $past(TB1.tick || TB2.tick))
      else $error("compare event without timebase tick");
   a_pin_cause: assert property ($changed(CMP_OUT[0]) |-> $past(TB1.tick || TB2.tick))
      else $error("pin changed without timebase tick");
endmodule

bind ocp_channel_pair ocp_checker i_ocp_checker (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .TB1(TB1), .TB2(TB2), .CPU_SLEEP(CPU_SLEEP),
   .CPU_IDLE(CPU_IDLE), .FAULT_IN_N(FAULT_IN_N), .CMP_OUT(CMP_OUT), .CMP_OE(CMP_OE),
   .CMP_EVENT(CMP_EVENT), .TB_EVENT(TB_EVENT)
);

`default_nettype wire

// ### ocp_pin_load.sv
// Load on the compare pins and source of the fault inputs
`timescale 1ns/1ps
`default_nettype none

module ocp_pin_load #(
   parameter logic pull_level = 1'h1
) (
   input  wire logic [1:0] drv,
   input  wire logic [1:0] oe,
   input  wire logic [1:0] trip,
   output logic      [1:0] pin,
   output logic      [1:0] fault_n
);
   // Released pin settles to the pull level
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin[i] = oe[i] ? drv[i] : pull_level;
      end
   end
   assign fault_n = ~trip;
endmodule

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the compare channel pair
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defines.svh"

module tb_top
   import ocp_pkg::*;
;
   localparam logic [15:0] per_val = 16'h0009;
   logic        mclk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   logic        run = 1'h0, tick = 1'h0, tb_idle = 1'h0, cpu_sleep = 1'h0, cpu_idle = 1'h0;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [15:0] cnt = 16'h0000;
   logic [1:0]  trip = 2'h0, fault_n, cmp_out, cmp_oe, cmp_event, tb_event, pin;
   logic        avs_waitrequest;
   ocp_tb_t     tb1, tb2;
   int          err_count = 0, samples_checked = 0, cycles = 0;
   integer      hi, ev, te, chg;

   always #4 mclk = ~mclk;
   assign tb1 = '{cnt, per_val, run, tb_idle, tick};
   assign tb2 = tb1;
   always @(posedge mclk) begin
      tick <= run;
      if (run) cnt <= (cnt == per_val) ? 16'h0000 : cnt + 16'h0001;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         tally_and_finish();
      end
   end

   ocp_channel_pair i_ocp_channel_pair (
      .MCLK(mclk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .TB1(tb1), .TB2(tb2),
      .CPU_SLEEP(cpu_sleep), .CPU_IDLE(cpu_idle), .DEBUG_HALT(1'h0), .FAULT_IN_N(fault_n),
      .CMP_OUT(cmp_out), .CMP_OE(cmp_oe), .CMP_EVENT(cmp_event), .TB_EVENT(tb_event));
   ocp_pin_load i_ocp_pin_load (.drv(cmp_out), .oe(cmp_oe), .trip(trip), .pin(pin),
      .fault_n(fault_n));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
      @(posedge mclk);
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {16'h0000, wd};
      // Waits for the answer; only the bench timeout ends a hang
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask
   task automatic rdc(input string what, input logic [9:0] idx, input logic [15:0] exp);
      bus(1'h0, idx, 16'h0000);
      chk(what, rd, {16'h0000, exp});
   endtask
   // Runs the timebase from a wrap for n counts, tallying pin activity
   task automatic measure(input int ch, input int n);
      logic last;
      {hi, ev, te, chg} = '0;
      @(posedge mclk);
      cnt <= per_val;
      run <= 1'h1;
      @(posedge mclk);
      @(negedge mclk);
      last = pin[ch];
      repeat (n) begin
         @(negedge mclk);
         hi += pin[ch];
         ev += cmp_event[ch];
         te += tb_event[ch];
         chg += (pin[ch] !== last);
         last = pin[ch];
      end
      @(posedge mclk);
      run <= 1'h0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_regs();
      for (int i = 0; i < 6; i++) rdc("reset value", `OCP_IDX_CH1_SEC + 10'(2 * i), 16'h0000);
      bus(1'h1, `OCP_IDX_CH1_SEC, 16'hA5C3);
      rdc("secondary readback", `OCP_IDX_CH1_SEC, 16'hA5C3);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'hFFFF);
      rdc("control fields", `OCP_IDX_CH1_CTRL, 16'h600F);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0000);
      bus(1'h1, 10'h190, 16'hFFFF);
      rdc("unmapped read", 10'h190, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_single();
      int mode [3] = '{3, 2, 1};
      int exp_hi [3] = '{10, 15, 5};
      bus(1'h1, `OCP_IDX_CH1_PRI, 16'h0014);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0003);
      measure(0, 20);
      chk("unreached compare", chg + ev, 0);
      bus(1'h1, `OCP_IDX_CH1_PRI, 16'h0005);
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, `OCP_IDX_CH1_CTRL, 16'(mode[i]));
         measure(0, 20);
         chk("single match high time", hi, exp_hi[i]);
         chk("single match events", ev, 2);
      end
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0000);
      measure(0, 20);
      chk("disabled activity", chg + ev, 0);
      $display("test single done");
   endtask
   task automatic t_dual();
      bus(1'h1, `OCP_IDX_CH1_PRI, 16'h0003);
      bus(1'h1, `OCP_IDX_CH1_SEC, 16'h0006);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0004);
      measure(0, 20);
      chk("single pulse width", hi, 3);
      chk("single pulse events", ev, 2);
      measure(0, 20);
      chk("no second pulse", hi + ev, 0);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0004);
      measure(0, 20);
      chk("rearmed pulse", hi, 3);
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0005);
      measure(0, 20);
      chk("continuous high time", hi, 6);
      chk("continuous events", ev, 4);
      $display("test dual done");
   endtask
   task automatic t_pwm();
      int duty [3] = '{4, 0, 12};
      int exp_hi [3] = '{8, 0, 20};
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0006);
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, `OCP_IDX_CH1_SEC, 16'(duty[i]));
         measure(0, 20);
         chk("pwm high time", hi, exp_hi[i]);
         chk("pwm period events", te, 2);
         chk("pwm compare quiet", ev, 0);
      end
      bus(1'h1, `OCP_IDX_CH1_PRI, 16'h0007);
      rdc("duty latch", `OCP_IDX_CH1_PRI, 16'h000C);
      $display("test pwm done");
   endtask
   task automatic t_fault();
      bus(1'h1, `OCP_IDX_CH1_CTRL, 16'h0000);
      bus(1'h1, `OCP_IDX_CH2_SEC, 16'h0005);
      bus(1'h1, `OCP_IDX_CH2_CTRL, 16'h000F);
      measure(1, 20);
      chk("second timebase high time", hi, 32'h0000_000A);
      chk("second timebase period events", te, 32'h0000_0002);
      @(posedge mclk);
      trip <= 2'h2;
      repeat (3) @(negedge mclk);
      chk("pin floats", {cmp_oe[1], pin[1]}, 2'h1);
      rdc("fault flag", `OCP_IDX_CH2_CTRL, 16'h001F);
      @(posedge mclk);
      trip <= 2'h0;
      repeat (3) @(negedge mclk);
      chk("float persists", cmp_oe[1], 1'h0);
      bus(1'h1, `OCP_IDX_CH2_CTRL, 16'h000F);
      repeat (2) @(negedge mclk);
      chk("pwm re-enabled", cmp_oe[1], 1'h1);
      $display("test fault done");
   endtask
   task automatic t_power();
      logic [3:0] cfg [4] = '{4'h8, 4'h6, 4'h5, 4'h4};
      int exp_chg [4] = '{0, 0, 0, 2};
      bus(1'h1, `OCP_IDX_CH1_PRI, 16'h0005);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, `OCP_IDX_CH1_CTRL, {2'h0, cfg[i][0], 13'h0003});
         @(posedge mclk);
         {cpu_sleep, cpu_idle, tb_idle} <= cfg[i][3:1];
         measure(0, 20);
         chk("power state toggles", chg, exp_chg[i]);
         @(posedge mclk);
         {cpu_sleep, cpu_idle, tb_idle} <= 3'h0;
      end
      $display("test power done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'h0;
      t_regs();
      t_single();
      t_dual();
      t_pwm();
      t_fault();
      t_power();
      tally_and_finish();
   end
endmodule

`default_nettype wire
